/* pif_regs.svh */
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

// Register byte offsets
`define PIF_OFS_FLAGS_ONE  8'h00
`define PIF_OFS_FLAGS_TWO  8'h04
`define PIF_OFS_IRQ_STATUS 8'h08
`define PIF_OFS_IRQ_ENABLE 8'h0C
`define PIF_OFS_IRQ_CLEAR  8'h10

// Bit positions of the first flag register
`define PIF_BIT_PARPORT    7
`define PIF_BIT_CONVDONE   6
`define PIF_BIT_RXFULL     5
`define PIF_BIT_TXEMPTY    4
`define PIF_BIT_SYNCDONE   3
`define PIF_BIT_CAPCMP     2
`define PIF_BIT_T2MATCH    1
`define PIF_BIT_T1OVF      0

// Unimplemented bit of the second flag register
`define PIF_BIT_TWO_UNIMPL 5

// Implemented masks
`define PIF_ONE_STICKY     8'hCF
`define PIF_PARPORT_MASK   8'h80
`define PIF_TWO_IMPL       8'hDF

// Reset values
`define PIF_FLAGS_RST      8'h00
`define PIF_IRQ_RST        16'h0000
`define PIF_WORD_RST       32'h0000_0000

// Bus responses
`define PIF_RESP_OKAY      2'b00
`define PIF_RESP_SLVERR    2'b10

`endif

/* pif_pkg.sv */
package pif_pkg;

    typedef enum logic [2:0] {
        PIF_CCP_CAPTURE = 3'b001,
        PIF_CCP_COMPARE = 3'b010,
        PIF_CCP_PWM     = 3'b100
    } pif_ccp_mode_e;

    typedef enum logic [1:0] {
        PIF_WR_IDLE = 2'b01,
        PIF_WR_RESP = 2'b10
    } pif_wr_state_e;

    typedef enum logic [1:0] {
        PIF_RD_IDLE = 2'b01,
        PIF_RD_DATA = 2'b10
    } pif_rd_state_e;

    typedef logic [7:0]  pif_flags_t;
    typedef logic [15:0] pif_irq_t;

endpackage : pif_pkg

/* pif_flag_bank.sv */
`timescale 1ns/1ps
module pif_flag_bank #(
    parameter int               WIDTH     = 8,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1,
    parameter logic [WIDTH-1:0] RST_VAL   = '0
) (
    // Clock, reset, enable
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // Hardware sets and software clears
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic [WIDTH-1:0] clrBits,
    // Flag state
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // Set wins over clear so a coincident event is never lost
    assign flags_next = IMPL_MASK & (setBits | (flags_reg & ~clrBits));
    assign flags      = flags_reg;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flags_reg <= RST_VAL;
        end else if (ce) begin
            flags_reg <= flags_next;
        end
    end

endmodule : pif_flag_bank

/* pif_event_map.sv */
`timescale 1ns/1ps
`include "pif_regs.svh"
module pif_event_map #(
    parameter bit HAS_PARPORT = 1'b1
) (
    // Clock, reset, enable
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   ce,
    // Peripheral events
    input  wire pif_pkg::pif_ccp_mode_e ccpMode,
    input  wire logic                   parPortAccess,
    input  wire logic                   convDone,
    input  wire logic                   rxBufferFull,
    input  wire logic                   txBufferEmpty,
    input  wire logic                   syncSerialDone,
    input  wire logic                   captureEvent,
    input  wire logic                   compareMatch,
    input  wire logic                   timer2Match,
    input  wire logic                   timer1Overflow,
    input  wire logic [7:0]             flagsTwoEvent,
    // Mapped sets
    output logic      [7:0]             stickySet,
    output logic      [15:0]            irqEvents
);

    logic rxPrev_reg;
    logic txPrev_reg;
    logic ccpHit;
    logic parHit;
    logic rxRise;
    logic txRise;

    // PWM mode leaves the capture/compare flag untouched
    assign ccpHit = (ccpMode == pif_pkg::PIF_CCP_CAPTURE && captureEvent) ||
                    (ccpMode == pif_pkg::PIF_CCP_COMPARE && compareMatch);
    assign parHit = HAS_PARPORT && parPortAccess;
    assign rxRise = rxBufferFull & ~rxPrev_reg;
    assign txRise = txBufferEmpty & ~txPrev_reg;

    always_comb begin
        stickySet = `PIF_FLAGS_RST;
        stickySet[`PIF_BIT_PARPORT]  = parHit;
        stickySet[`PIF_BIT_CONVDONE] = convDone;
        stickySet[`PIF_BIT_SYNCDONE] = syncSerialDone;
        stickySet[`PIF_BIT_CAPCMP]   = ccpHit;
        stickySet[`PIF_BIT_T2MATCH]  = timer2Match;
        stickySet[`PIF_BIT_T1OVF]    = timer1Overflow;
    end

    // Buffer flags are levels; the interrupt status sees their rising edge
    always_comb begin
        irqEvents = {flagsTwoEvent & `PIF_TWO_IMPL, stickySet};
        irqEvents[`PIF_BIT_RXFULL]  = rxRise;
        irqEvents[`PIF_BIT_TXEMPTY] = txRise;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rxPrev_reg <= 1'b0;
            txPrev_reg <= 1'b0;
        end else if (ce) begin
            rxPrev_reg <= rxBufferFull;
            txPrev_reg <= txBufferEmpty;
        end
    end

endmodule : pif_event_map

/* pif_flags_top.sv */
// What this block does
// - Parallel port access sets bit 7, sticky
// - Without parallel port, bit 7 reads zero
// - Conversion done sets bit 6, sticky
// - Bit 5 follows receive buffer full, read-only
// - Bit 4 follows transmit buffer empty, read-only
// - Synchronous serial completion sets bit 3, sticky
// - Capture mode: capture sets bit 2
// - Compare mode: compare match sets bit 2; PWM unused
// - Timer two period match sets bit 1
// - Timer one overflow sets bit 0
// - Second register bit 5 reads zero
// - Flags set regardless of any interrupt enable
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pif_regs.svh"
module pif_flags_top #(
    parameter int ADDR_W      = 8,
    parameter bit HAS_PARPORT = 1'b1
) (
    // Clock, reset, enable
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   ce,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]             s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // AXI4-Lite read data
    output logic      [31:0]            s_axi_rdata,
    output logic      [1:0]             s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Peripheral events and levels
    input  wire pif_pkg::pif_ccp_mode_e ccpMode,
    input  wire logic                   parPortAccess,
    input  wire logic                   convDone,
    input  wire logic                   rxBufferFull,
    input  wire logic                   txBufferEmpty,
    input  wire logic                   syncSerialDone,
    input  wire logic                   captureEvent,
    input  wire logic                   compareMatch,
    input  wire logic                   timer2Match,
    input  wire logic                   timer1Overflow,
    input  wire logic [7:0]             flagsTwoEvent,
    // Interrupt
    output logic                        irq
);

    localparam logic [7:0] ONE_MASK = HAS_PARPORT ? `PIF_ONE_STICKY :
                                      (`PIF_ONE_STICKY & ~`PIF_PARPORT_MASK);

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == `PIF_OFS_FLAGS_ONE)  || (a == `PIF_OFS_FLAGS_TWO) ||
                   (a == `PIF_OFS_IRQ_STATUS) || (a == `PIF_OFS_IRQ_ENABLE) ||
                   (a == `PIF_OFS_IRQ_CLEAR);
    endfunction : isMapped

    // Write channel state
    pif_pkg::pif_wr_state_e wrState_reg;
    logic [ADDR_W-1:0]      wrAddr_reg;
    logic [31:0]            wrData_reg;
    logic [3:0]             wrStrb_reg;
    logic                   awHeld_reg;
    logic                   wHeld_reg;
    logic [1:0]             bresp_reg;

    // Read channel state
    pif_pkg::pif_rd_state_e rdState_reg;
    logic [31:0]            rdata_reg;
    logic [1:0]             rresp_reg;
    logic [31:0]            rdWord;

    // Register state
    pif_pkg::pif_flags_t    stickyOne;
    pif_pkg::pif_flags_t    flagsOne;
    pif_pkg::pif_flags_t    flagsTwo;
    pif_pkg::pif_irq_t      irqStatus;
    pif_pkg::pif_irq_t      irqEnable_reg;
    pif_pkg::pif_irq_t      irqEnable_next;
    logic [1:0]             bufLevel_reg;
    logic                   irq_reg;

    // Decode and strobes
    logic                   awTake;
    logic                   wTake;
    logic                   wrCommit;
    logic                   wrSelOne;
    logic                   wrSelTwo;
    logic                   wrSelEnable;
    logic                   wrSelClear;
    logic                   lane0;
    logic                   lane1;
    logic [7:0]             clrOne;
    logic [7:0]             clrTwo;
    pif_pkg::pif_irq_t      clrStatus;
    logic [7:0]             stickySet;
    pif_pkg::pif_irq_t      irqEvents;
    logic                   arTake;

    // Handshakes freeze with the clock enable so no beat is lost
    assign s_axi_awready = ce && !awHeld_reg && (wrState_reg == pif_pkg::PIF_WR_IDLE);
    assign s_axi_wready  = ce && !wHeld_reg && (wrState_reg == pif_pkg::PIF_WR_IDLE);
    assign s_axi_bvalid  = ce && (wrState_reg == pif_pkg::PIF_WR_RESP);
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ce && (rdState_reg == pif_pkg::PIF_RD_IDLE);
    assign s_axi_rvalid  = ce && (rdState_reg == pif_pkg::PIF_RD_DATA);
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = irq_reg;

    assign awTake   = s_axi_awvalid && s_axi_awready;
    assign wTake    = s_axi_wvalid && s_axi_wready;
    assign arTake   = s_axi_arvalid && s_axi_arready;
    assign wrCommit = ce && awHeld_reg && wHeld_reg && (wrState_reg == pif_pkg::PIF_WR_IDLE);

    assign wrSelOne    = wrCommit && (wrAddr_reg[7:0] == `PIF_OFS_FLAGS_ONE);
    assign wrSelTwo    = wrCommit && (wrAddr_reg[7:0] == `PIF_OFS_FLAGS_TWO);
    assign wrSelEnable = wrCommit && (wrAddr_reg[7:0] == `PIF_OFS_IRQ_ENABLE);
    assign wrSelClear  = wrCommit && (wrAddr_reg[7:0] == `PIF_OFS_IRQ_CLEAR);
    assign lane0       = wrStrb_reg[0];
    assign lane1       = wrStrb_reg[1];

    // A zero written to a sticky flag of either flag register clears it; a one leaves it alone
    assign clrOne = (wrSelOne && lane0) ? ~wrData_reg[7:0] : `PIF_FLAGS_RST;
    assign clrTwo = (wrSelTwo && lane0) ? ~wrData_reg[7:0] : `PIF_FLAGS_RST;
    assign clrStatus = wrSelClear ? {lane1 ? wrData_reg[15:8] : 8'h00,
                                     lane0 ? wrData_reg[7:0]  : 8'h00} : `PIF_IRQ_RST;
    assign irqEnable_next = {(wrSelEnable && lane1) ? wrData_reg[15:8] : irqEnable_reg[15:8],
                             (wrSelEnable && lane0) ? wrData_reg[7:0]  : irqEnable_reg[7:0]};

    // Buffer flags are registered copies of the peripheral's buffer state, one clock behind
    always_comb begin
        flagsOne = stickyOne;
        flagsOne[`PIF_BIT_RXFULL]  = bufLevel_reg[1];
        flagsOne[`PIF_BIT_TXEMPTY] = bufLevel_reg[0];
    end

    always_comb begin
        rdWord = `PIF_WORD_RST;
        if (s_axi_araddr[7:0] == `PIF_OFS_FLAGS_ONE) begin
            rdWord[7:0] = flagsOne;
        end else if (s_axi_araddr[7:0] == `PIF_OFS_FLAGS_TWO) begin
            rdWord[7:0] = flagsTwo;
        end else if (s_axi_araddr[7:0] == `PIF_OFS_IRQ_STATUS) begin
            rdWord[15:0] = irqStatus;
        end else if (s_axi_araddr[7:0] == `PIF_OFS_IRQ_ENABLE) begin
            rdWord[15:0] = irqEnable_reg;
        end
    end

    pif_event_map #(
        .HAS_PARPORT    (HAS_PARPORT)
    ) u_map (
        .clock          (clock),
        .rst_b          (rst_b),
        .ce             (ce),
        .ccpMode        (ccpMode),
        .parPortAccess  (parPortAccess),
        .convDone       (convDone),
        .rxBufferFull   (rxBufferFull),
        .txBufferEmpty  (txBufferEmpty),
        .syncSerialDone (syncSerialDone),
        .captureEvent   (captureEvent),
        .compareMatch   (compareMatch),
        .timer2Match    (timer2Match),
        .timer1Overflow (timer1Overflow),
        .flagsTwoEvent  (flagsTwoEvent),
        .stickySet      (stickySet),
        .irqEvents      (irqEvents)
    );

    // Flag sets ignore the interrupt enables so software can poll
    pif_flag_bank #(
        .WIDTH     (8),
        .IMPL_MASK (ONE_MASK),
        .RST_VAL   (`PIF_FLAGS_RST)
    ) u_one (
        .clock     (clock),
        .rst_b     (rst_b),
        .ce        (ce),
        .setBits   (stickySet),
        .clrBits   (clrOne),
        .flags     (stickyOne)
    );

    pif_flag_bank #(
        .WIDTH     (8),
        .IMPL_MASK (`PIF_TWO_IMPL),
        .RST_VAL   (`PIF_FLAGS_RST)
    ) u_two (
        .clock     (clock),
        .rst_b     (rst_b),
        .ce        (ce),
        .setBits   (flagsTwoEvent),
        .clrBits   (clrTwo),
        .flags     (flagsTwo)
    );

    pif_flag_bank #(
        .WIDTH     (16),
        .IMPL_MASK ({`PIF_TWO_IMPL, 8'hFF}),
        .RST_VAL   (`PIF_IRQ_RST)
    ) u_status (
        .clock     (clock),
        .rst_b     (rst_b),
        .ce        (ce),
        .setBits   (irqEvents),
        .clrBits   (clrStatus),
        .flags     (irqStatus)
    );

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bufLevel_reg  <= 2'b00;
            irqEnable_reg <= `PIF_IRQ_RST;
            irq_reg       <= 1'b0;
        end else if (ce) begin
            bufLevel_reg  <= {rxBufferFull, txBufferEmpty};
            irqEnable_reg <= irqEnable_next;
            irq_reg       <= |(irqStatus & irqEnable_reg);
        end
    end

    // Address and data are taken in either order, then committed together
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrState_reg <= pif_pkg::PIF_WR_IDLE;
            wrAddr_reg  <= '0;
            wrData_reg  <= `PIF_WORD_RST;
            wrStrb_reg  <= 4'h0;
            awHeld_reg  <= 1'b0;
            wHeld_reg   <= 1'b0;
            bresp_reg   <= `PIF_RESP_OKAY;
        end else if (ce) begin
            case (wrState_reg)
                pif_pkg::PIF_WR_IDLE: begin
                    if (awTake) begin
                        wrAddr_reg <= s_axi_awaddr;
                        awHeld_reg <= 1'b1;
                    end
                    if (wTake) begin
                        wrData_reg <= s_axi_wdata;
                        wrStrb_reg <= s_axi_wstrb;
                        wHeld_reg  <= 1'b1;
                    end
                    if (wrCommit) begin
                        awHeld_reg  <= 1'b0;
                        wHeld_reg   <= 1'b0;
                        bresp_reg   <= isMapped(wrAddr_reg[7:0]) ? `PIF_RESP_OKAY :
                                                                  `PIF_RESP_SLVERR;
                        wrState_reg <= pif_pkg::PIF_WR_RESP;
                    end
                end
                pif_pkg::PIF_WR_RESP: begin
                    if (s_axi_bready) begin
                        wrState_reg <= pif_pkg::PIF_WR_IDLE;
                    end
                end
                default: begin
                    wrState_reg <= pif_pkg::PIF_WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdState_reg <= pif_pkg::PIF_RD_IDLE;
            rdata_reg   <= `PIF_WORD_RST;
            rresp_reg   <= `PIF_RESP_OKAY;
        end else if (ce) begin
            case (rdState_reg)
                pif_pkg::PIF_RD_IDLE: begin
                    if (arTake) begin
                        rdata_reg   <= rdWord;
                        rresp_reg   <= isMapped(s_axi_araddr[7:0]) ? `PIF_RESP_OKAY :
                                                                    `PIF_RESP_SLVERR;
                        rdState_reg <= pif_pkg::PIF_RD_DATA;
                    end
                end
                pif_pkg::PIF_RD_DATA: begin
                    if (s_axi_rready) begin
                        rdState_reg <= pif_pkg::PIF_RD_IDLE;
                    end
                end
                default: begin
                    rdState_reg <= pif_pkg::PIF_RD_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    chk_parport_sets: assert property (
        ce && parPortAccess && HAS_PARPORT |=> flagsOne[`PIF_BIT_PARPORT])
        else $error("parallel port access did not set its flag");

    chk_parport_absent: assert property (
        HAS_PARPORT || !flagsOne[`PIF_BIT_PARPORT])
        else $error("absent parallel port flag reads one");

    chk_conv_sticky: assert property (
        ce && convDone ##1 (!ce || clrOne[`PIF_BIT_CONVDONE] == 1'b0)
        |-> flagsOne[`PIF_BIT_CONVDONE] ##1 flagsOne[`PIF_BIT_CONVDONE])
        else $error("conversion flag not held");

    chk_rx_follows: assert property (
        ce
        |=> flagsOne[`PIF_BIT_RXFULL] == $past(rxBufferFull))
        else $error("receive flag does not follow buffer");

    chk_tx_follows: assert property (
        ce |=> flagsOne[`PIF_BIT_TXEMPTY] == $past(txBufferEmpty))
        else $error("transmit flag does not follow buffer");

    chk_sync_sets: assert property (
        ce && syncSerialDone |=> flagsOne[`PIF_BIT_SYNCDONE])
        else $error("sync serial completion did not set flag");

    chk_capture_sets: assert property (
        ce && captureEvent && ccpMode == pif_pkg::PIF_CCP_CAPTURE
        |=> flagsOne[`PIF_BIT_CAPCMP])
        else $error("capture did not set flag");

    chk_pwm_unused: assert property (
        ce && ccpMode == pif_pkg::PIF_CCP_PWM && !flagsOne[`PIF_BIT_CAPCMP]
        |=> !flagsOne[`PIF_BIT_CAPCMP])
        else $error("flag set in pwm mode");

    chk_t2_sets: assert property (
        ce && timer2Match |=> flagsOne[`PIF_BIT_T2MATCH])
        else $error("timer two match did not set flag");

    chk_t1_sets: assert property (
        ce && timer1Overflow |=> flagsOne[`PIF_BIT_T1OVF])
        else $error("timer one overflow did not set flag");

    chk_two_unimpl: assert property (
        !flagsTwo[`PIF_BIT_TWO_UNIMPL])
        else $error("unimplemented bit reads one");

    chk_poll_set: assert property (
        ce && flagsTwoEvent[0] && irqEnable_reg == `PIF_IRQ_RST |=> flagsTwo[0])
        else $error("flag not set while disabled");

    chk_zero_clears: assert property (
        wrSelOne && lane0 && !wrData_reg[`PIF_BIT_T1OVF] && !timer1Overflow
        |=> !flagsOne[`PIF_BIT_T1OVF])
        else $error("write of zero did not clear flag");

    chk_irq_level: assert property (
        ce && |(irqStatus & irqEnable_reg) |=> irq)
        else $error("interrupt not raised for enabled status");

    cov_flag_write: cover property (wrSelOne ##[1:4] s_axi_bvalid && s_axi_bready);
    cov_irq_raise: cover property (!irq ##1 irq);
    cov_set_vs_clear: cover property (wrSelOne && lane0 && timer2Match);

endmodule : pif_flags_top

/* pif_periph_model.sv */
`timescale 1ns/1ps
module pif_periph_model (
    // Clock
    input  wire logic clock,
    // Event pulses and buffer levels
    output logic [6:0] evt,
    output logic       rxFull,
    output logic       txEmpty,
    output logic [7:0] twoEvt
);
    initial begin
        evt = 7'h00;
        rxFull = 1'b0;
        txEmpty = 1'b0;
        twoEvt = 8'h00;
    end
    // Exactly one cycle high; a held level would keep setting the flag
    task automatic pulse(input int idx, input logic [7:0] two);
        @(posedge clock);
        if (idx >= 0) evt[idx] <= 1'b1;
        twoEvt <= two;
        @(posedge clock);
        evt <= 7'h00;
        twoEvt <= 8'h00;
    endtask : pulse
    task automatic levels(input logic rx, input logic tx);
        @(posedge clock);
        rxFull <= rx;
        txEmpty <= tx;
    endtask : levels
endmodule : pif_periph_model

/* testbench.sv */
`timescale 1ns/1ps
`include "pif_regs.svh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
    logic        clock, rst_b, ce;
    logic [7:0]  awAddr, arAddr, twoEvt;
    logic [31:0] wData, rData;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp;
    logic        awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady, irq, rxFull, txEmpty;
    logic [6:0]  evt;
    int          failures, numChecks, cycles;
    pif_pkg::pif_ccp_mode_e ccpMode;
    localparam logic [1:0] OKR = `PIF_RESP_OKAY;
    localparam logic [1:0] ERR = `PIF_RESP_SLVERR;
    localparam logic [7:0] F1 = `PIF_OFS_FLAGS_ONE;
    localparam logic [7:0] F2 = `PIF_OFS_FLAGS_TWO;
    logic [7:0]  evBit [7] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01};

    pif_flags_top dut (
        .clock(clock), .rst_b(rst_b), .ce(ce),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .ccpMode(ccpMode),
        .parPortAccess(evt[0]), .convDone(evt[1]), .rxBufferFull(rxFull),
        .txBufferEmpty(txEmpty), .syncSerialDone(evt[2]), .captureEvent(evt[3]),
        .compareMatch(evt[4]), .timer2Match(evt[5]), .timer1Overflow(evt[6]),
        .flagsTwoEvent(twoEvt), .irq(irq)
    );
    pif_periph_model peri (
        .clock(clock), .evt(evt), .rxFull(rxFull), .txEmpty(txEmpty), .twoEvt(twoEvt)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic finish_test;
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            finish_test();
        end
    end

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awAddr <= a;
        wData <= d;
        wStrb <= 4'h3;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clock);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while ((awValid && !awReady) || (wValid && !wReady));
        do @(posedge clock); while (!bValid);
        `CHK("bresp", er, bResp)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clock); while (!arReady);
        arValid <= 1'b0;
        do @(posedge clock); while (!rValid);
        `CHK("rdata", e, rData)
        `CHK("rresp", er, rResp)
    endtask : rd

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        {awAddr, arAddr, wData, wStrb} = '0;
        {awValid, wValid, bReady, arValid, rReady, cycles} = '0;
        {failures, numChecks} = '0;
        ccpMode = pif_pkg::PIF_CCP_CAPTURE;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(F1, 32'h0000_0000, OKR);
        rd(F2, 32'h0000_0000, OKR);
        rd(`PIF_OFS_IRQ_STATUS, 32'h0000_0000, OKR);
        rd(8'h14, 32'h0000_0000, ERR);
        wr(8'h14, 32'hFFFF_FFFF, ERR);
        $display("test reset done");
        // Enables stay zero here, so every flag must still set
        foreach (evBit[i]) begin
            ccpMode <= (i == 4) ? pif_pkg::PIF_CCP_COMPARE : pif_pkg::PIF_CCP_CAPTURE;
            peri.pulse(i, 8'h00);
            rd(F1, {24'h00_0000, evBit[i]}, OKR);
            wr(F1, {24'hFF_FFFF, ~evBit[i]}, OKR);
            rd(F1, 32'h0000_0000, OKR);
        end
        ccpMode <= pif_pkg::PIF_CCP_PWM;
        peri.pulse(4, 8'h00);
        rd(F1, 32'h0000_0000, OKR);
        $display("test sticky done");
        peri.levels(1'b1, 1'b1);
        wr(F1, 32'h0000_0000, OKR);
        rd(F1, 32'h0000_0030, OKR);
        peri.levels(1'b0, 1'b0);
        // Buffer flags lag their levels by one clock
        @(posedge clock);
        rd(F1, 32'h0000_0000, OKR);
        peri.pulse(-1, 8'hFF);
        rd(F2, 32'h0000_00DF, OKR);
        wr(F2, 32'h0000_0020, OKR);
        rd(F2, 32'h0000_0000, OKR);
        $display("test levels done");
        rd(`PIF_OFS_IRQ_STATUS, 32'h0000_DFFF, OKR);
        `CHK("irq", 1'b0, irq)
        wr(`PIF_OFS_IRQ_CLEAR, 32'h0000_FFFF, OKR);
        rd(`PIF_OFS_IRQ_STATUS, 32'h0000_0000, OKR);
        rd(`PIF_OFS_IRQ_CLEAR, 32'h0000_0000, OKR);
        wr(`PIF_OFS_IRQ_ENABLE, 32'h0000_0001, OKR);
        rd(`PIF_OFS_IRQ_ENABLE, 32'h0000_0001, OKR);
        peri.pulse(6, 8'h00);
        repeat (3) @(posedge clock);
        `CHK("irq", 1'b1, irq)
        wr(F1, 32'h0000_00FE, OKR);
        wr(`PIF_OFS_IRQ_CLEAR, 32'h0000_0001, OKR);
        repeat (2) @(posedge clock);
        `CHK("irq", 1'b0, irq)
        // Masked source: flag sets but the line stays low
        peri.pulse(5, 8'h00);
        repeat (3) @(posedge clock);
        `CHK("irq", 1'b0, irq)
        rd(F1, 32'h0000_0002, OKR);
        // Events while the clock enable is low are lost
        ce <= 1'b0;
        peri.pulse(6, 8'h00);
        ce <= 1'b1;
        rd(F1, 32'h0000_0002, OKR);
        $display("test interrupt done");
        finish_test();
    end
endmodule : testbench
